// >>> verilog/msar_cfg.svh
/*
  Constants of the main stream attribute register bank: byte offsets,
  field positions, reset values and tick timing.
  Assumes inclusion from msar_pkg.sv, msar_regs.sv and the bench.
*/
`ifndef MSAR_CFG_SVH
`define MSAR_CFG_SVH

// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define MSAR_ADDR_W 12
`define MSAR_RESP_OKAY 2'h0
`define MSAR_RESP_SLVERR 2'h2

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define MSAR_OFF_INT_STATUS 12'h140
`define MSAR_OFF_INT_MASK 12'h144
`define MSAR_OFF_PULSE_LEN 12'h150
`define MSAR_OFF_US_COUNT 12'h154
`define MSAR_OFF_LINE_TOTAL 12'h180
`define MSAR_OFF_FRAME_TOTAL 12'h184
`define MSAR_OFF_SYNC_POL 12'h188
`define MSAR_OFF_HS_WIDTH 12'h18c
`define MSAR_OFF_VS_WIDTH 12'h190
`define MSAR_OFF_H_ACTIVE 12'h194
`define MSAR_OFF_V_ACTIVE 12'h198
`define MSAR_OFF_H_START 12'h19c
`define MSAR_OFF_V_START 12'h1a0
`define MSAR_OFF_ATTR_A 12'h1a4
`define MSAR_OFF_ATTR_B 12'h1a8

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define MSAR_BIT_HP_FLAG 4
`define MSAR_ATTR_B_WMASK 8'h87
`define MSAR_MASK_RST 1'b1
`define MSAR_ATTR_RST '0

// ---------------------------------------------------------------
// Microsecond time base
// ---------------------------------------------------------------
`define MSAR_CLK_FREQ_MHZ 250
`define MSAR_TICK_PERIOD_US 1
`define MSAR_TICK_CYCLES (`MSAR_CLK_FREQ_MHZ * `MSAR_TICK_PERIOD_US)

`endif

// >>> verilog/msar_pkg.sv
/*
  Types of the main stream attribute register bank.
  Assumes msar_cfg.svh is on the include path.
*/
`include "msar_cfg.svh"

package msar_pkg;

  // Attribute set handed to the framing logic
  typedef struct packed {
    logic [15:0] h_total;
    logic [15:0] v_total;
    logic [1:0] sync_pol;
    logic [14:0] hs_width;
    logic [14:0] vs_width;
    logic [15:0] h_active;
    logic [15:0] v_active;
    logic [15:0] h_start;
    logic [15:0] v_start;
    logic [7:0] attr_a;
    logic [7:0] attr_b;
  } msar_attr_t;

  // Hot-plug pulse watcher states
  typedef enum logic [1:0] {
    MSAR_HP_WAIT = 2'b00,
    MSAR_HP_HIGH = 2'b01,
    MSAR_HP_LOW = 2'b10
  } msar_hp_state_t;

endpackage

// >>> verilog/msar_regs.sv
/*
  Main stream attribute register bank with hot-plug pulse timer,
  reached over AXI4-Lite.
  Assumes hpd_in is already synchronous to clk_sys, clk_en is held
  high during bus traffic, and the framing logic samples attr.
*/
`include "msar_cfg.svh"


module msar_regs (
  input wire logic clk_sys, // 250 MHz register clock
  input wire logic nrst, // Asynchronous reset, low
  input wire logic clk_en, // Freezes all state when low
  input wire logic hpd_in, // Hot-plug line level
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output msar_pkg::msar_attr_t attr, // Stream attributes out
  output logic irq // Level interrupt, high
);
  import msar_pkg::*;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Word match of a byte address against a register offset
  function automatic logic hit(input logic [11:0] addr,
                               input logic [11:0] off);
    hit = (addr[11:2] == off[11:2]);
  endfunction

  // Any implemented register at this address
  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, `MSAR_OFF_INT_STATUS) ||
             hit(addr, `MSAR_OFF_INT_MASK) ||
             hit(addr, `MSAR_OFF_PULSE_LEN) ||
             hit(addr, `MSAR_OFF_US_COUNT) ||
             (addr[11:2] >= `MSAR_OFF_LINE_TOTAL >> 2 &&
              addr[11:2] <= `MSAR_OFF_ATTR_B >> 2);
  endfunction

  // Byte-lane merge of new write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [11:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_word;
  logic wr_go;
  logic rd_go;
  msar_attr_t attr_reg;
  logic status_reg;
  logic mask_reg;
  logic [7:0] tick_cnt_reg;
  logic tick;
  logic [31:0] free_cnt_reg;
  msar_hp_state_t hp_state_reg;
  logic [15:0] hp_len_cnt_reg;
  logic [15:0] pulse_len_reg;
  logic pulse_end;

  // ---------------------------------------------------------------
  // AXI4-Lite handshakes
  // ---------------------------------------------------------------

  // Readies drop with clk_en so no beat is taken while frozen
  assign s_axi_awready = clk_en && !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = clk_en && !w_full_reg && !bvalid_reg;
  assign s_axi_arready = clk_en && !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg && clk_en;
  assign s_axi_rvalid = rvalid_reg && clk_en;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign wr_go = aw_full_reg && w_full_reg;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Write address holding, either order with data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_addr_reg <= 12'h000;
      aw_full_reg <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
    end
  end

  // Write data holding
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      w_full_reg <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped words answer SLVERR
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `MSAR_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? `MSAR_RESP_OKAY
                                         : `MSAR_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data mux, unused upper bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(s_axi_araddr, `MSAR_OFF_INT_STATUS)) begin
      rd_word[`MSAR_BIT_HP_FLAG] = status_reg;
    end else if (hit(s_axi_araddr, `MSAR_OFF_INT_MASK)) begin
      rd_word[`MSAR_BIT_HP_FLAG] = mask_reg;
    end else if (hit(s_axi_araddr, `MSAR_OFF_PULSE_LEN)) begin
      rd_word[15:0] = pulse_len_reg;
    end else if (hit(s_axi_araddr, `MSAR_OFF_US_COUNT)) begin
      rd_word = free_cnt_reg;
    end else if (hit(s_axi_araddr, `MSAR_OFF_LINE_TOTAL)) begin
      rd_word[15:0] = attr_reg.h_total;
    end else if (hit(s_axi_araddr, `MSAR_OFF_FRAME_TOTAL)) begin
      rd_word[15:0] = attr_reg.v_total;
    end else if (hit(s_axi_araddr, `MSAR_OFF_SYNC_POL)) begin
      rd_word[1:0] = attr_reg.sync_pol;
    end else if (hit(s_axi_araddr, `MSAR_OFF_HS_WIDTH)) begin
      rd_word[14:0] = attr_reg.hs_width;
    end else if (hit(s_axi_araddr, `MSAR_OFF_VS_WIDTH)) begin
      rd_word[14:0] = attr_reg.vs_width;
    end else if (hit(s_axi_araddr, `MSAR_OFF_H_ACTIVE)) begin
      rd_word[15:0] = attr_reg.h_active;
    end else if (hit(s_axi_araddr, `MSAR_OFF_V_ACTIVE)) begin
      rd_word[15:0] = attr_reg.v_active;
    end else if (hit(s_axi_araddr, `MSAR_OFF_H_START)) begin
      rd_word[15:0] = attr_reg.h_start;
    end else if (hit(s_axi_araddr, `MSAR_OFF_V_START)) begin
      rd_word[15:0] = attr_reg.v_start;
    end else if (hit(s_axi_araddr, `MSAR_OFF_ATTR_A)) begin
      rd_word[7:0] = attr_reg.attr_a;
    end else if (hit(s_axi_araddr, `MSAR_OFF_ATTR_B)) begin
      rd_word[7:0] = attr_reg.attr_b;
    end
  end

  // Read answer registered one cycle after the address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `MSAR_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= mapped(s_axi_araddr) ? `MSAR_RESP_OKAY
                                          : `MSAR_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stream attribute registers
  // ---------------------------------------------------------------

  // Register writes with byte strobes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      attr_reg <= `MSAR_ATTR_RST;
    end else if (clk_en && wr_go) begin
      if (hit(aw_addr_reg, `MSAR_OFF_LINE_TOTAL)) begin
        attr_reg.h_total <= 16'(merge({16'h0000, attr_reg.h_total},
                                      w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_FRAME_TOTAL)) begin
        attr_reg.v_total <= 16'(merge({16'h0000, attr_reg.v_total},
                                      w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_SYNC_POL)) begin
        attr_reg.sync_pol <= 2'(merge({30'h0, attr_reg.sync_pol},
                                      w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_HS_WIDTH)) begin
        attr_reg.hs_width <= 15'(merge({17'h0, attr_reg.hs_width},
                                       w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_VS_WIDTH)) begin
        attr_reg.vs_width <= 15'(merge({17'h0, attr_reg.vs_width},
                                       w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_H_ACTIVE)) begin
        attr_reg.h_active <= 16'(merge({16'h0000, attr_reg.h_active},
                                       w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_V_ACTIVE)) begin
        attr_reg.v_active <= 16'(merge({16'h0000, attr_reg.v_active},
                                       w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_H_START)) begin
        attr_reg.h_start <= 16'(merge({16'h0000, attr_reg.h_start},
                                      w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_V_START)) begin
        attr_reg.v_start <= 16'(merge({16'h0000, attr_reg.v_start},
                                      w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_ATTR_A)) begin
        attr_reg.attr_a <= 8'(merge({24'h0, attr_reg.attr_a},
                                    w_data_reg, w_strb_reg));
      end
      if (hit(aw_addr_reg, `MSAR_OFF_ATTR_B)) begin
        attr_reg.attr_b <= 8'(merge({24'h0, attr_reg.attr_b},
                                    w_data_reg, w_strb_reg))
                           & `MSAR_ATTR_B_WMASK;
      end
    end
  end

  assign attr = attr_reg;

  // ---------------------------------------------------------------
  // Microsecond time base
  // ---------------------------------------------------------------

  // Divider from 250 MHz down to a 1 MHz tick
  assign tick = (tick_cnt_reg == 8'(`MSAR_TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 8'h00;
    end else if (clk_en) begin
      tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      free_cnt_reg <= 32'h0000_0000;
    end else if (clk_en && tick) begin
      free_cnt_reg <= free_cnt_reg + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Hot-plug pulse timer
  // ---------------------------------------------------------------

  // A pulse is a low excursion ending on the rise of the line
  assign pulse_end = (hp_state_reg == MSAR_HP_LOW) && hpd_in;

  // Wait for a high line first so a low line at reset is no pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hp_state_reg <= MSAR_HP_WAIT;
      hp_len_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      case (hp_state_reg)
        MSAR_HP_WAIT: begin
          if (hpd_in) begin
            hp_state_reg <= MSAR_HP_HIGH;
          end
        end
        MSAR_HP_HIGH: begin
          if (!hpd_in) begin
            hp_state_reg <= MSAR_HP_LOW;
            hp_len_cnt_reg <= 16'h0000;
          end
        end
        MSAR_HP_LOW: begin
          if (hpd_in) begin
            hp_state_reg <= MSAR_HP_HIGH;
          end else if (tick && hp_len_cnt_reg != 16'hffff) begin
            // Saturate rather than wrap on very long lows
            hp_len_cnt_reg <= hp_len_cnt_reg + 16'h0001;
          end
        end
        default: begin
          hp_state_reg <= MSAR_HP_WAIT;
        end
      endcase
    end
  end

  // latch length at pulse end, hold
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulse_len_reg <= 16'h0000;
    end else if (clk_en && pulse_end) begin
      pulse_len_reg <= hp_len_cnt_reg;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------

  // sticky flag; new pulse beats read clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_reg <= 1'b0;
    end else if (clk_en) begin
      if (pulse_end) begin
        status_reg <= 1'b1;
      end else if (rd_go && hit(s_axi_araddr, `MSAR_OFF_INT_STATUS)) begin
        status_reg <= 1'b0;
      end
    end
  end

  // Mask bit set means masked; starts masked
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= `MSAR_MASK_RST;
    end else if (clk_en && wr_go && w_strb_reg[0] &&
                 hit(aw_addr_reg, `MSAR_OFF_INT_MASK)) begin
      mask_reg <= w_data_reg[`MSAR_BIT_HP_FLAG];
    end
  end

  assign irq = status_reg && !mask_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_PULSE_LEN: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && pulse_end) |=> pulse_len_reg == $past(hp_len_cnt_reg))
    else $error("pulse length not latched at pulse end");
  AST_LEN_HOLD: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !(clk_en && pulse_end) |=> $stable(pulse_len_reg))
    else $error("pulse length changed without a pulse end");
  AST_US_STEP: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && tick) |=> free_cnt_reg == $past(free_cnt_reg) + 32'h1)
    else $error("microsecond count did not step on tick");
  AST_US_GAP: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && tick) |=> !tick [*8])
    else $error("ticks closer than the divider allows");
  AST_LINE_TOTAL: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_go && w_strb_reg == 4'hf &&
     hit(aw_addr_reg, `MSAR_OFF_LINE_TOTAL))
    |=> attr.h_total == $past(w_data_reg[15:0]))
    else $error("line total not written");
  AST_FRAME_TOTAL: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_go && w_strb_reg == 4'hf &&
     hit(aw_addr_reg, `MSAR_OFF_FRAME_TOTAL))
    |=> attr.v_total == $past(w_data_reg[15:0]))
    else $error("frame total not written");
  AST_POLARITY: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_go && w_strb_reg[0] &&
     hit(aw_addr_reg, `MSAR_OFF_SYNC_POL))
    |=> attr.sync_pol == $past(w_data_reg[1:0]))
    else $error("sync polarity not written");
  AST_HS_WIDTH: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && wr_go && w_strb_reg == 4'hf &&
     hit(aw_addr_reg, `MSAR_OFF_HS_WIDTH))
    |=> attr.hs_width == $past(w_data_reg[14:0]))
    else $error("hsync width not written");
  AST_ATTR_B_RSVD: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    attr.attr_b[6:3] == 4'h0)
    else $error("reserved attribute bits not zero");
  AST_HP_FLAG: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clk_en && pulse_end) |=> status_reg ##1 (status_reg || $past(rd_go)))
    else $error("pulse flag not raised or lost");

endmodule // msar_regs

// >>> dv/msar_regs_tb.sv
/*
  Self-checking bench for the main stream attribute register bank.
  Assumes msar_pkg.sv and msar_regs.sv are compiled before it.
*/
`include "msar_cfg.svh"

module msar_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import msar_pkg::*;

  // ----------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------
  logic clk_sys, nrst, clk_en, hpd_in, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  msar_attr_t attr;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [33:0] exp_q[$];
  localparam logic [1:0] OK = `MSAR_RESP_OKAY;
  localparam logic [1:0] ERR = `MSAR_RESP_SLVERR;
  // Readable bits of the attribute words, 0x180 upward
  localparam logic [31:0] MSK [11] = '{32'hffff, 32'hffff, 32'h3,
    32'h7fff, 32'h7fff, 32'hffff, 32'hffff, 32'hffff, 32'hffff,
    32'hff, 32'h87};

  msar_regs u_msar_regs (.clk_sys(clk_sys), .nrst(nrst),
    .clk_en(clk_en), .hpd_in(hpd_in), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .attr(attr), .irq(irq));

  // ----------------------------------------------------------
  // Clock, cycle count, helpers
  // ----------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Cycles since reset release, used to predict the tick count
  always @(posedge clk_sys) if (nrst === 1'b1) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [143:0] seen, input logic [143:0] e);
    num_checks++;
    if (seen !== e) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Bus master tasks; each notes its expected answer
  // ----------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Address and data may be taken on different edges
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // Hot-plug line low for an exact number of cycles
  task automatic pulse(input int n);
    @(posedge clk_sys);
    hpd_in <= 1'b0;
    repeat (n) @(posedge clk_sys);
    hpd_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // Reads the tick counter mid-period so phase cannot matter
  task automatic tick_read();
    while (cyc % 250 != 125) @(posedge clk_sys);
    rd(`MSAR_OFF_US_COUNT, cyc / 250, OK);
  endtask

  // Response monitor: oldest note against each answer
  always @(posedge clk_sys) begin
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
      if (exp_q.size() > 0) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      else check(1, 0);
    end else if ((s_axi_bvalid & s_axi_bready) === 1'b1) begin
      if (exp_q.size() > 0) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
      else check(1, 0);
    end
  end

  // Watchdog well beyond the expected run of about 1900 cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    complete_run();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] seed;
    logic [31:0] v [11];
    {nrst, hpd_in, clk_en} = 3'b011;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    seed = 32'h00011984;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    check(attr, 0);
    check(irq, 0);
    rd(`MSAR_OFF_INT_MASK, 32'h10, OK);
    for (int p = 0; p < 2; p++) begin
      // Random words, then all ones to hit every field edge
      for (int i = 0; i < 11; i++) begin
        seed = lfsr(seed);
        v[i] = (p == 1) ? 32'hffffffff : seed;
        wr(12'h180 + 12'(4 * i), v[i], OK);
        v[i] = v[i] & MSK[i];
        rd(12'h180 + 12'(4 * i), v[i], OK);
      end
      @(posedge clk_sys);
      check(attr, {v[0][15:0], v[1][15:0], v[2][1:0], v[3][14:0],
        v[4][14:0], v[5][15:0], v[6][15:0], v[7][15:0], v[8][15:0],
        v[9][7:0], v[10][7:0]});
    end
    wr(12'h1ac, 32'h1, ERR);
    rd(12'h1ac, 32'h0, ERR);
    tick_read();
    pulse(750);
    check(irq, 0);
    rd(`MSAR_OFF_PULSE_LEN, 32'h3, OK);
    rd(`MSAR_OFF_INT_STATUS, 32'h10, OK);
    rd(`MSAR_OFF_INT_STATUS, 32'h0, OK);
    wr(`MSAR_OFF_INT_MASK, 32'h0, OK);
    wr(`MSAR_OFF_PULSE_LEN, 32'hffff, OK);
    rd(`MSAR_OFF_PULSE_LEN, 32'h3, OK);
    // Mid-period phase so a 500-cycle low always spans two ticks
    while (cyc % 250 != 100) @(posedge clk_sys);
    pulse(500);
    check(irq, 1);
    rd(`MSAR_OFF_PULSE_LEN, 32'h2, OK);
    rd(`MSAR_OFF_INT_STATUS, 32'h10, OK);
    @(posedge clk_sys);
    check(irq, 0);
    tick_read();
    // Frozen bank offers no bus readiness
    clk_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(s_axi_arready, 0);
    check(s_axi_awready, 0);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    complete_run();
  end

endmodule // msar_regs_tb
